/* logic/pmc_pkg.sv */
// constants, field layout and state types of the power mode control register block
package pmc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] PMC_ADDR_CTRL = 12'h000;
  localparam logic [11:0] PMC_ADDR_STAT = 12'h004;
  localparam int PMC_ADDR_W = 12;
  localparam logic [31:0] PMC_CTRL_RESET = 32'h0000c000;
  localparam logic [31:0] PMC_CTRL_WMASK = 32'h000fcdff;
  localparam logic [1:0] PMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;
  // ****************************************
  // field codes
  // ****************************************
  localparam logic [1:0] PMC_LD_OFF = 2'h0;
  localparam logic [1:0] PMC_LD_ON = 2'h3;
  localparam logic [1:0] PMC_VSEL_RSVD = 2'h0;
  localparam logic [1:0] PMC_VSEL_LOW = 2'h1;
  localparam logic [1:0] PMC_VSEL_MID = 2'h2;
  localparam logic [1:0] PMC_VSEL_HIGH = 2'h3;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic [1:0] low_driver_enable_field;
    logic high_drive_switch;
    logic high_drive_enable;
    logic [1:0] regulator_voltage_select;
    logic [1:0] rsvd_13;
    logic lowdrive_normal_regulator;
    logic lowdrive_lowpower_regulator;
    logic rsvd_9;
    logic backup_write_enable;
    logic [2:0] lowvolt_threshold;
    logic lowvolt_detect_enable;
    logic standby_flag_clear;
    logic wakeup_flag_clear;
    logic standby_select;
    logic regulator_low_power;
  } pmc_ctrl_t;
  typedef enum logic [2:0] {
    PMC_RUN = 3'h1,
    PMC_DEEP = 3'h2,
    PMC_STBY = 3'h4
  } pmc_mode_t;
  typedef struct packed {
    pmc_ctrl_t ctrl;
    pmc_mode_t mode;
    logic standby_flag;
    logic wakeup_flag;
    logic aw_v;
    logic [PMC_ADDR_W-1:0] aw_addr;
    logic w_v;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmc_state_t;
endpackage : pmc_pkg

/* logic/pmc_top.sv */
// power mode control register with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module pmc_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic deep_sleep_request_i,
  input wire logic deep_sleep_exit_i,
  input wire logic standby_wake_i,
  input wire logic wakeup_event_i,
  input wire logic high_drive_ready_flag_i,
  input wire logic osc_is_sysclk_i,
  input wire logic pll_on_i,
  input wire logic backup_write_req_i,
  output logic backup_write_o,
  output logic deep_sleep_o,
  output logic standby_o,
  output logic regulator_low_power_o,
  output logic low_drive_o,
  output logic high_drive_mode_o,
  output logic [1:0] regulator_voltage_o,
  output logic lowvolt_detect_enable_o,
  output logic [2:0] lowvolt_threshold_o,
  output logic standby_flag_o,
  output logic wakeup_flag_o
);
  // ****************************************
  // state
  // ****************************************
  pmc_pkg::pmc_state_t st_r;
  pmc_pkg::pmc_state_t st_nxt;
  pmc_pkg::pmc_ctrl_t wr_val;
  logic [31:0] bmask;
  logic [31:0] merged;
  logic do_write;
  logic ctrl_hit;
  logic stat_hit;
  logic rd_ctrl;
  logic rd_stat;
  logic clr_stb;
  logic clr_wu;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    wr_val = st_r.ctrl;
    bmask = {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}}, {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};
    merged = 32'h00000000;
    clr_stb = 1'b0;
    clr_wu = 1'b0;
    ctrl_hit = (st_r.aw_addr == pmc_pkg::PMC_ADDR_CTRL);
    stat_hit = (st_r.aw_addr == pmc_pkg::PMC_ADDR_STAT);
    rd_ctrl = (s_axi_araddr == pmc_pkg::PMC_ADDR_CTRL);
    rd_stat = (s_axi_araddr == pmc_pkg::PMC_ADDR_STAT);
    do_write = st_r.aw_v && st_r.w_v && !st_r.bvalid;
    // address and data capture, either order
    if (s_axi_awvalid && !st_r.aw_v)
    begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_v)
    begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (do_write)
    begin
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (ctrl_hit || stat_hit) ? pmc_pkg::PMC_RESP_OKAY : pmc_pkg::PMC_RESP_SLVERR;
      if (ctrl_hit)
      begin
        // byte lanes allow byte, half-word or word access
        merged = (32'(st_r.ctrl) & ~(bmask & pmc_pkg::PMC_CTRL_WMASK))
               | (st_r.w_data & bmask & pmc_pkg::PMC_CTRL_WMASK);
        wr_val = pmc_pkg::pmc_ctrl_t'(merged);
        if (wr_val.high_drive_switch && !st_r.ctrl.high_drive_switch
            && !(high_drive_ready_flag_i && osc_is_sysclk_i))
        begin
          wr_val.high_drive_switch = 1'b0;
        end
        if (wr_val.high_drive_enable && !st_r.ctrl.high_drive_enable && !osc_is_sysclk_i)
        begin
          wr_val.high_drive_enable = 1'b0;
        end
        if (pll_on_i)
        begin
          wr_val.regulator_voltage_select = st_r.ctrl.regulator_voltage_select;
        end
        clr_stb = wr_val.standby_flag_clear;
        clr_wu = wr_val.wakeup_flag_clear;
        wr_val.standby_flag_clear = 1'b0;
        wr_val.wakeup_flag_clear = 1'b0;
        st_nxt.ctrl = wr_val;
      end
    end
    // read channel
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = (rd_ctrl || rd_stat) ? pmc_pkg::PMC_RESP_OKAY : pmc_pkg::PMC_RESP_SLVERR;
      if (rd_ctrl)
      begin
        st_nxt.rdata = 32'(st_r.ctrl);
      end
      else if (rd_stat)
      begin
        st_nxt.rdata = {30'h00000000, st_r.standby_flag, st_r.wakeup_flag};
      end
      else
      begin
        st_nxt.rdata = 32'h00000000;
      end
    end
    // flags: set wins over clear
    if (clr_stb)
    begin
      st_nxt.standby_flag = 1'b0;
    end
    if (clr_wu)
    begin
      st_nxt.wakeup_flag = 1'b0;
    end
    if (wakeup_event_i)
    begin
      st_nxt.wakeup_flag = 1'b1;
    end
    // power mode sequencing
    unique case (st_r.mode)
      pmc_pkg::PMC_RUN:
      begin
        if (deep_sleep_request_i)
        begin
          st_nxt.mode = st_nxt.ctrl.standby_select ? pmc_pkg::PMC_STBY : pmc_pkg::PMC_DEEP;
        end
      end
      pmc_pkg::PMC_DEEP:
      begin
        if (deep_sleep_exit_i)
        begin
          st_nxt.mode = pmc_pkg::PMC_RUN;
          st_nxt.ctrl.high_drive_switch = 1'b0;
          st_nxt.ctrl.high_drive_enable = 1'b0;
        end
      end
      pmc_pkg::PMC_STBY:
      begin
        st_nxt.standby_flag = 1'b1;
      end
    endcase
    if (!st_nxt.ctrl.high_drive_enable)
    begin
      st_nxt.ctrl.high_drive_switch = 1'b0;
    end
    // wake from standby reloads control and returns to run mode; flags keep their value
    if (standby_wake_i)
    begin
      st_nxt.ctrl = pmc_pkg::pmc_ctrl_t'(pmc_pkg::PMC_CTRL_RESET);
      st_nxt.mode = pmc_pkg::PMC_RUN;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
      st_r.ctrl <= pmc_pkg::pmc_ctrl_t'(pmc_pkg::PMC_CTRL_RESET);
      st_r.mode <= pmc_pkg::PMC_RUN;
    end
    else if (en_i)
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = !st_r.aw_v;
  assign s_axi_wready = !st_r.w_v;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign backup_write_o = backup_write_req_i && st_r.ctrl.backup_write_enable;
  assign deep_sleep_o = (st_r.mode == pmc_pkg::PMC_DEEP);
  assign standby_o = (st_r.mode == pmc_pkg::PMC_STBY);
  assign regulator_low_power_o = deep_sleep_o && st_r.ctrl.regulator_low_power;
  assign low_drive_o = deep_sleep_o && (st_r.ctrl.low_driver_enable_field == pmc_pkg::PMC_LD_ON)
    && (st_r.ctrl.regulator_low_power ? st_r.ctrl.lowdrive_lowpower_regulator
                                      : st_r.ctrl.lowdrive_normal_regulator);
  assign high_drive_mode_o = st_r.ctrl.high_drive_switch;
  assign regulator_voltage_o = (!pll_on_i || st_r.ctrl.regulator_voltage_select == pmc_pkg::PMC_VSEL_RSVD)
    ? pmc_pkg::PMC_VSEL_LOW : st_r.ctrl.regulator_voltage_select;
  assign lowvolt_detect_enable_o = st_r.ctrl.lowvolt_detect_enable && !standby_o;
  assign lowvolt_threshold_o = st_r.ctrl.lowvolt_threshold;
  assign standby_flag_o = st_r.standby_flag;
  assign wakeup_flag_o = st_r.wakeup_flag;
endmodule : pmc_top
`default_nettype wire

/* test/pmc_assertions.sv */
// concurrent checks on the power mode control block ports
`timescale 1ns/1ps
`default_nettype none
module pmc_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic deep_sleep_exit_i,
  input wire logic standby_wake_i,
  input wire logic wakeup_event_i,
  input wire logic pll_on_i,
  input wire logic backup_write_req_i,
  input wire logic backup_write_o,
  input wire logic deep_sleep_o,
  input wire logic standby_o,
  input wire logic low_drive_o,
  input wire logic high_drive_mode_o,
  input wire logic [1:0] regulator_voltage_o,
  input wire logic lowvolt_detect_enable_o,
  input wire logic standby_flag_o,
  input wire logic wakeup_flag_o
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_wake;
    en_i && standby_o && standby_wake_i;
  endsequence
  sequence s_exit;
    en_i && deep_sleep_o && deep_sleep_exit_i;
  endsequence
  a_wake_run: assert property (s_wake |=> !standby_o && !high_drive_mode_o) else $error("wake");
  a_mode_excl: assert property (!(deep_sleep_o && standby_o)) else $error("modes");
  a_ld_deep: assert property (low_drive_o |-> deep_sleep_o) else $error("low drive");
  a_volt_nopll: assert property (!pll_on_i |-> regulator_voltage_o == 2'h1) else $error("volt");
  a_volt_code: assert property (regulator_voltage_o != 2'h0) else $error("code");
  a_bkp_gate: assert property (backup_write_o |-> backup_write_req_i) else $error("backup");
  a_det_stby: assert property (standby_o |-> !lowvolt_detect_enable_o) else $error("det");
  a_wake_flag: assert property (en_i && wakeup_event_i |=> wakeup_flag_o) else $error("wflag");
  a_stby_flag: assert property (en_i && standby_o |=> standby_flag_o) else $error("sflag");
  a_drv_exit: assert property (s_exit |=> !high_drive_mode_o && !deep_sleep_o) else $error("exit");
endmodule : pmc_assertions
bind pmc_top pmc_assertions i_chk (.*);
`default_nettype wire

/* test/pmc_top_tb.sv */
// self-checking testbench for the power mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, s); end end
module pmc_top_tb;
  logic clk_i = 1'b0, nrst_i = 1'b0, en_i = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, m, d, rv;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'h0, ev = 4'h0, sb;
  logic high_drive_ready_flag_i = 1'b0, osc_is_sysclk_i = 1'b0, pll_on_i = 1'b0, backup_write_req_i = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, backup_write_o, deep_sleep_o;
  logic standby_o, regulator_low_power_o, low_drive_o, high_drive_mode_o, lowvolt_detect_enable_o;
  logic standby_flag_o, wakeup_flag_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, regulator_voltage_o, rs;
  logic [2:0] lowvolt_threshold_o;
  logic [31:0] tv [4] = '{32'h000fc401, 32'h000fc800, 32'h0007cc01, 32'h000fc801};
  wire logic deep_sleep_request_i = ev[0];
  wire logic deep_sleep_exit_i = ev[1];
  wire logic standby_wake_i = ev[2];
  wire logic wakeup_event_i = ev[3];
  int error_cnt = 0, comparisons = 0, seed = 32'h3165, i;
  always #2.5 clk_i = ~clk_i;
  pmc_top i_dut (.*);
  // ****
  // bus tasks and model
  // ****
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic pulse(input int b);
    @(posedge clk_i);
    ev[b] <= 1'b1;
    @(posedge clk_i);
    ev[b] <= 1'b0;
    @(negedge clk_i);
  endtask : pulse
  function automatic logic [31:0] mwr(input logic [31:0] o, input logic [31:0] v, input logic [3:0] s);
    logic [31:0] k;
    k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h000fcdf3;
    if (!osc_is_sysclk_i) v[16] = v[16] & o[16];
    if (!(osc_is_sysclk_i && high_drive_ready_flag_i)) v[17] = v[17] & o[17];
    if (pll_on_i) k[15:14] = 2'h0;
    v = (o & ~k) | (v & k);
    v[17] = v[17] & v[16];
    return v;
  endfunction : mwr
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // ****
  // tests
  // ****
  initial
  begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(12'h000);
    `CHK("reset", 32'h0000c000, rv)
    m = 32'h0000c000;
    for (i = 0; i < 40; i++)
    begin
      d = $random(seed) & 32'h000fcdff;
      rv = $random(seed);
      osc_is_sysclk_i <= rv[20];
      high_drive_ready_flag_i <= rv[21];
      pll_on_i <= rv[22];
      backup_write_req_i <= rv[23];
      sb = rv[24] ? 4'hf : (rv[25] ? 4'h3 : 4'hc);
      wr(12'h000, d, sb);
      m = mwr(m, d, sb);
      rd(12'h000);
      `CHK("ctrl", m, rv)
      `CHK("drive", m[17], high_drive_mode_o)
      `CHK("thr", m[7:5], lowvolt_threshold_o)
      `CHK("det", m[4], lowvolt_detect_enable_o)
      `CHK("volt", (pll_on_i && m[15:14] != 2'h0) ? m[15:14] : 2'h1, regulator_voltage_o)
      `CHK("bkp", backup_write_req_i & m[8], backup_write_o)
    end
    wr(12'h008, 32'h000fffff, 4'hf);
    `CHK("bresp", 2'h2, rs)
    rd(12'h008);
    `CHK("rresp", 2'h2, rs)
    $display("test registers done");
    pulse(3);
    `CHK("wflag", 1'b1, wakeup_flag_o)
    rd(12'h004);
    `CHK("stat", 32'h00000001, rv)
    wr(12'h000, m | 32'h4, 4'hf);
    @(negedge clk_i);
    `CHK("wclr", 1'b0, wakeup_flag_o)
    m = mwr(m, m | 32'h2, 4'hf);
    wr(12'h000, m, 4'hf);
    pulse(0);
    `CHK("stby", 2'h1, {deep_sleep_o, standby_o})
    @(negedge clk_i);
    `CHK("sflag", 1'b1, standby_flag_o)
    pulse(2);
    m = 32'h0000c000;
    rd(12'h000);
    `CHK("wake", m, rv)
    `CHK("skeep", 1'b1, standby_flag_o)
    wr(12'h000, m | 32'h8, 4'hf);
    @(negedge clk_i);
    `CHK("sclr", 1'b0, standby_flag_o)
    $display("test flags done");
    osc_is_sysclk_i <= 1'b1;
    high_drive_ready_flag_i <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      wr(12'h000, tv[i], 4'hf);
      m = mwr(m, tv[i], 4'hf);
      pulse(0);
      `CHK("deep", 2'h2, {deep_sleep_o, standby_o})
      `CHK("lp", m[0], regulator_low_power_o)
      `CHK("ld", m[19:18] == 2'h3 && (m[0] ? m[10] : m[11]), low_drive_o)
      `CHK("drive", 1'b1, high_drive_mode_o)
      pulse(1);
      m[17:16] = 2'h0;
      rd(12'h000);
      `CHK("exit", m, rv)
    end
    $display("test deep sleep done");
    tally_and_finish();
  end
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : pmc_top_tb
`default_nettype wire
